/* File: inc/zcb_pkg.sv */
// Package with the encodings and field positions of the compare-with-zero branch unit.
package zcb_pkg;
    localparam int unsigned OPC_HI = 31;
    localparam int unsigned OPC_LO = 26;
    localparam int unsigned SRC_HI = 25;
    localparam int unsigned SRC_LO = 21;
    localparam int unsigned SEC_HI = 20;
    localparam int unsigned SEC_LO = 16;
    localparam int unsigned DISP_HI = 15;
    localparam int unsigned DISP_LO = 0;
    localparam logic [5:0] OPC_REG_IMM_GROUP = 6'h01;
    localparam logic [5:0] OPC_LE = 6'h06;
    localparam logic [5:0] OPC_GT = 6'h07;
    localparam logic [5:0] OPC_LE_LIKELY = 6'h16;
    localparam logic [5:0] OPC_GT_LIKELY = 6'h17;
    localparam logic [4:0] SEC_LT = 5'h00;
    localparam logic [4:0] SEC_GE_LIKELY = 5'h03;
    localparam logic [4:0] SEC_GE_LINK = 5'h11;
    localparam logic [4:0] SEC_GE_LINK_LIKELY = 5'h13;
    localparam logic [4:0] SEC_ZERO = 5'h00;
    localparam logic [4:0] LINK_REG = 5'h1F;
    localparam int unsigned LINK_STEP = 8;
    localparam int unsigned DISP_SHIFT = 2;

    // Comparison kinds against zero.
    typedef enum logic [1:0] {
        CMP_GE,
        CMP_GT,
        CMP_LE,
        CMP_LT
    } cmp_kind_t;
endpackage

/* File: design/zcb_decode.sv */
// Combinational decoder for the compare-with-zero branch words.
`timescale 1ns/100ps
`default_nettype none
module zcb_decode
(
    input  wire logic [31:0]         word,     // Instruction word.
    output logic                     is_branch, // Word is a covered branch.
    output zcb_pkg::cmp_kind_t       kind,     // Comparison to apply.
    output logic                     likely,   // Likely variant.
    output logic                     link,     // Link variant.
    output logic [4:0]               src_reg,  // Tested register number.
    output logic [15:0]              disp      // Raw displacement.
);
    logic [5:0] opc;
    logic [4:0] sec;

    // Field split of the branch word.
    assign opc     = word[zcb_pkg::OPC_HI:zcb_pkg::OPC_LO];
    assign sec     = word[zcb_pkg::SEC_HI:zcb_pkg::SEC_LO];
    assign src_reg = word[zcb_pkg::SRC_HI:zcb_pkg::SRC_LO];
    assign disp    = word[zcb_pkg::DISP_HI:zcb_pkg::DISP_LO];

    // Opcode and secondary field select the operation; anything else is not ours.
    always_comb
    begin
        is_branch = 1'b0;
        kind      = zcb_pkg::CMP_GE;
        likely    = 1'b0;
        link      = 1'b0;
        if (opc == zcb_pkg::OPC_REG_IMM_GROUP)
        begin
            unique case (sec)
                zcb_pkg::SEC_GE_LINK:        begin is_branch = 1'b1; link = 1'b1; end
                zcb_pkg::SEC_GE_LINK_LIKELY: begin is_branch = 1'b1; link = 1'b1; likely = 1'b1; end
                zcb_pkg::SEC_GE_LIKELY:      begin is_branch = 1'b1; likely = 1'b1; end
                zcb_pkg::SEC_LT:             begin is_branch = 1'b1; kind = zcb_pkg::CMP_LT; end
                default:                     is_branch = 1'b0;
            endcase
        end
        else if (sec == zcb_pkg::SEC_ZERO)
        begin
            unique case (opc)
                zcb_pkg::OPC_GT:        begin is_branch = 1'b1; kind = zcb_pkg::CMP_GT; end
                zcb_pkg::OPC_GT_LIKELY: begin is_branch = 1'b1; kind = zcb_pkg::CMP_GT; likely = 1'b1; end
                zcb_pkg::OPC_LE_LIKELY: begin is_branch = 1'b1; kind = zcb_pkg::CMP_LE; likely = 1'b1; end
                zcb_pkg::OPC_LE:        begin is_branch = 1'b1; kind = zcb_pkg::CMP_LE; end
                default:                is_branch = 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: design/zero_compare_branch_unit.sv */
// Compare-with-zero branch unit: decode, condition, target, link and delay-slot control.
`timescale 1ns/100ps
`default_nettype none
module zero_compare_branch_unit #(
    parameter int unsigned XLEN = 64 // General register width.
)
(
    input  wire logic            sys_clk,      // Core clock, 25 MHz.
    input  wire logic            nrst,         // Asynchronous reset, active low.
    input  wire logic            clk_en,       // Freezes all state while low.
    input  wire logic            issue,        // One-cycle pulse: an instruction is presented.
    input  wire logic [31:0]     word,         // Instruction word presented with issue.
    input  wire logic [XLEN-1:0] pc,           // Address of the presented instruction.
    input  wire logic [XLEN-1:0] src_value,    // Value of the tested register for this word.
    output logic [4:0]           src_sel,      // Register number to read, registered.
    output logic                 decoded,      // Branch recognised at previous issue.
    output logic                 link_we,      // Pulse: write link value to register.
    output logic [4:0]           link_reg,     // Register written by the link.
    output logic [XLEN-1:0]      link_value,   // Branch address plus 8.
    output logic                 redirect,     // Pulse: load target into the PC.
    output logic [XLEN-1:0]      target,       // Branch target address.
    output logic                 nullify       // Pulse: discard the delay-slot instruction.
);
    // Refuse widths narrower than a word at elaboration; the 18-bit offset and 32-bit words need the room.
    generate
        if (XLEN < 32)
        begin : g_bad_xlen
            $error("XLEN must be at least 32");
        end
    endgenerate

    logic                 dec_branch;
    zcb_pkg::cmp_kind_t   dec_kind;
    logic                 dec_likely;
    logic                 dec_link;
    logic [4:0]           dec_src;
    logic [15:0]          dec_disp;

    zcb_decode u_decode
    (
        .word      (word),
        .is_branch (dec_branch),
        .kind      (dec_kind),
        .likely    (dec_likely),
        .link      (dec_link),
        .src_reg   (dec_src),
        .disp      (dec_disp)
    );

    // Pending-branch state held between the branch and its delay slot.
    logic            pend;
    logic            pend_cond;
    logic            pend_likely;
    logic [XLEN-1:0] pend_target;
    logic            next_pend;
    logic            next_pend_cond;
    logic            next_pend_likely;
    logic [XLEN-1:0] next_pend_target;
    logic [4:0]      next_src_sel;
    logic            next_decoded;
    logic            next_link_we;
    logic [4:0]      next_link_reg;
    logic [XLEN-1:0] next_link_value;
    logic            next_redirect;
    logic [XLEN-1:0] next_target;
    logic            next_nullify;
    logic            sign_bit;
    logic            is_zero;
    logic            cond;
    logic [XLEN-1:0] offset;

    // Full-width tests; the sign comes from the top bit XLEN-1, not from a fixed bit 31.
    assign sign_bit = src_value[XLEN-1];
    assign is_zero  = (src_value == '0);

    // Displacement scaled by four and sign-extended as an 18-bit value.
    assign offset = {{(XLEN-18){dec_disp[15]}}, dec_disp, 2'b00};

    // Condition for each comparison kind.
    always_comb
    begin
        unique case (dec_kind)
            zcb_pkg::CMP_GE: cond = ~sign_bit;
            zcb_pkg::CMP_GT: cond = ~sign_bit & ~is_zero;
            zcb_pkg::CMP_LE: cond = sign_bit | is_zero;
            zcb_pkg::CMP_LT: cond = sign_bit;
        endcase
    end

    // Next values: a branch records its outcome; the following issue applies it.
    always_comb
    begin
        next_pend        = pend;
        next_pend_cond   = pend_cond;
        next_pend_likely = pend_likely;
        next_pend_target = pend_target;
        next_src_sel     = src_sel;
        next_decoded     = decoded;
        next_link_we     = 1'b0;
        next_link_reg    = link_reg;
        next_link_value  = link_value;
        next_redirect    = 1'b0;
        next_target      = target;
        next_nullify     = 1'b0;
        if (issue)
        begin
            next_src_sel = dec_src;
            if (pend)
            begin
                // The delay-slot instruction is being processed now.
                next_redirect = pend_cond;
                next_target   = pend_target;
                next_nullify  = pend_likely & ~pend_cond;
                next_pend     = 1'b0;
                next_decoded  = 1'b0;
            end
            else
            begin
                // A branch in a delay slot is not served; the slot is ordinary code.
                next_decoded     = dec_branch;
                next_pend        = dec_branch;
                next_pend_cond   = cond;
                next_pend_likely = dec_likely;
                next_pend_target = pc + XLEN'(4) + offset;
                if (dec_branch && dec_link)
                begin
                    // Written even when untaken, so the link is visible in the slot.
                    next_link_we    = 1'b1;
                    next_link_reg   = zcb_pkg::LINK_REG;
                    next_link_value = pc + XLEN'(zcb_pkg::LINK_STEP);
                end
            end
        end
    end

    // Registers only; clock enable freezes everything.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pend        <= 1'b0;
            pend_cond   <= 1'b0;
            pend_likely <= 1'b0;
            pend_target <= '0;
            src_sel     <= 5'h00;
            decoded     <= 1'b0;
            link_we     <= 1'b0;
            link_reg    <= 5'h00;
            link_value  <= '0;
            redirect    <= 1'b0;
            target      <= '0;
            nullify     <= 1'b0;
        end
        else if (clk_en)
        begin
            pend        <= next_pend;
            pend_cond   <= next_pend_cond;
            pend_likely <= next_pend_likely;
            pend_target <= next_pend_target;
            src_sel     <= next_src_sel;
            decoded     <= next_decoded;
            link_we     <= next_link_we;
            link_reg    <= next_link_reg;
            link_value  <= next_link_value;
            redirect    <= next_redirect;
            target      <= next_target;
            nullify     <= next_nullify;
        end
    end

    // Checks on the observable outcome.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    link_value_a: assert property (clk_en && issue && !pend && dec_branch && dec_link |=> link_we
        && link_reg == 5'h1F && link_value == $past(pc) + XLEN'(zcb_pkg::LINK_STEP)) else $error("link write wrong");
    // A pulse frozen by a low clock enable is an old pulse, so only freshly loaded ones are traced back.
    redirect_slot_a: assert property (redirect && $past(clk_en) |-> $past(issue) && $past(pend) && $past(pend_cond))
        else $error("redirect not at slot");
    nullify_likely_a: assert property (nullify && $past(clk_en) |-> $past(pend_likely) && !$past(pend_cond))
        else $error("bad nullify");
    excl_pulses_a: assert property (!(redirect && nullify)) else $error("redirect and nullify together");
    ge_sign_a: assert property (issue && !pend && dec_kind == zcb_pkg::CMP_GE |-> cond == !src_value[XLEN-1]) else $error("ge condition");
    gt_cond_a: assert property (issue && !pend && dec_kind == zcb_pkg::CMP_GT |-> cond == (!src_value[XLEN-1] && src_value != 0)) else $error("gt condition");
    le_cond_a: assert property (issue && !pend && dec_kind == zcb_pkg::CMP_LE |-> cond == (src_value[XLEN-1] || src_value == 0)) else $error("le condition");
    lt_sign_a: assert property (issue && !pend && dec_kind == zcb_pkg::CMP_LT |-> cond == src_value[XLEN-1]) else $error("lt condition");
    // Target rebuilt from the branch word and address two edges back, not from the pending copy.
    target_sum_a: assert property (clk_en && issue && !pend && dec_branch ##1 clk_en && issue |=>
        target == $past(pc, 2) + XLEN'(4) + {{(XLEN-18){$past(word[15], 2)}}, $past(word[15:0], 2), 2'b00})
        else $error("target wrong");
    pend_hold_a: assert property (pend && !issue |=> pend) else $error("pending lost");

    taken_c: cover property (issue && pend && pend_cond ##1 redirect);
    nullified_c: cover property (nullify);
    link_c: cover property (link_we ##[1:4] redirect);
endmodule
`default_nettype wire

/* File: bench/zcb_core_model.sv */
// Register file partner: supplies the tested register and takes link writes.
`timescale 1ns/100ps
`default_nettype none
module zcb_core_model
(
    input  wire logic        sys_clk,    // Core clock.
    input  wire logic        clk_en,     // Clock enable.
    input  wire logic [4:0]  rd_addr,    // Register to read.
    output logic [63:0]      rd_data,    // Read value, same cycle.
    input  wire logic        link_we,    // Link write strobe.
    input  wire logic [4:0]  link_reg,   // Link register number.
    input  wire logic [63:0] link_value  // Link value.
);
    logic [63:0] regs [32];
    // Register zero reads as zero, as the architectural file does.
    assign rd_data = (rd_addr == 5'h00) ? 64'h0 : regs[rd_addr];
    // Plain always so the bench may preload registers directly between branches.
    always @(posedge sys_clk)
    begin
        if (clk_en && link_we)
            regs[link_reg] <= link_value;
    end
endmodule
`default_nettype wire

/* File: bench/zero_compare_branch_unit_bench.sv */
// Random and corner-case self-checking bench for the compare-with-zero branch unit.
`timescale 1ns/100ps
`default_nettype none
module zero_compare_branch_unit_bench;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        clk_en = 1'b1;
    logic        issue = 1'b0;
    logic [31:0] word = 32'h0;
    logic [63:0] pc = 64'h0;
    logic [63:0] src_value;
    logic [4:0]  src_sel;
    logic [4:0]  link_reg;
    logic        decoded, link_we, redirect, nullify;
    logic [63:0] link_value, target;
    int          fails = 0;
    int          tests_run = 0;
    int          cycles = 0;
    // Entry layout: opcode, secondary field, covered, kind, likely, link.
    localparam logic [15:0] TBL [10] = '{{6'h01, 5'h11, 1'b1, 2'd0, 2'b01}, {6'h01, 5'h13, 1'b1, 2'd0, 2'b11},
        {6'h01, 5'h03, 1'b1, 2'd0, 2'b10}, {6'h01, 5'h00, 1'b1, 2'd3, 2'b00}, {6'h07, 5'h00, 1'b1, 2'd1, 2'b00},
        {6'h17, 5'h00, 1'b1, 2'd1, 2'b10}, {6'h06, 5'h00, 1'b1, 2'd2, 2'b00}, {6'h16, 5'h00, 1'b1, 2'd2, 2'b10},
        {6'h01, 5'h10, 1'b0, 2'd0, 2'b00}, {6'h07, 5'h01, 1'b0, 2'd0, 2'b00}};

    zero_compare_branch_unit #(.XLEN(64)) zero_compare_branch_unit_i (.sys_clk(sys_clk), .nrst(nrst),
        .clk_en(clk_en), .issue(issue), .word(word), .pc(pc), .src_value(src_value), .src_sel(src_sel),
        .decoded(decoded), .link_we(link_we), .link_reg(link_reg), .link_value(link_value),
        .redirect(redirect), .target(target), .nullify(nullify));
    zcb_core_model zcb_core_model_i (.sys_clk(sys_clk), .clk_en(clk_en), .rd_addr(word[25:21]),
        .rd_data(src_value), .link_we(link_we), .link_reg(link_reg), .link_value(link_value));

    // Condition from the full 64-bit value; sign is the top bit.
    function automatic logic cond_of(input logic [1:0] k, input logic [63:0] v);
        case (k)
            2'd0: return !v[63];
            2'd1: return !v[63] && (v != 64'h0);
            2'd2: return v[63] || (v == 64'h0);
            default: return v[63];
        endcase
    endfunction

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (fails == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One cycle of drive, launched just after a rising edge.
    task automatic step(input logic iss, input logic [31:0] w, input logic [63:0] p, input logic en);
        @(posedge sys_clk);
        issue <= iss;
        word <= w;
        pc <= p;
        clk_en <= en;
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        nrst <= 1'b0;
        issue <= 1'b0;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
    endtask

    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end

    // A hang is cut short well beyond the fifteen hundred or so cycles the run needs.
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            give_verdict();
        end
    end

    initial
    begin
        logic [15:0] e, d;
        logic [63:0] v, p, tgt;
        logic [31:0] slot;
        logic [4:0]  r;
        logic        c;
        int          gaps;
        void'($urandom(32'hC2F65665));
        do_reset();
        #1;
        check("outputs after reset", {decoded, link_we, redirect, nullify}, 64'h0);
        for (int n = 0; n < 400; n++)
        begin
            e = TBL[n % 10];
            r = 5'(1 + $urandom % 30);
            case ($urandom % 8)
                0: v = 64'h0;
                1: v = 64'h1;
                2: v = 64'h8000000000000000;
                3: v = 64'hFFFFFFFFFFFFFFFF;
                4: v = 64'h0000000100000000;
                5: v = 64'h0000000080000000;
                6: v = 64'h7FFFFFFFFFFFFFFF;
                default: v = {$urandom, $urandom};
            endcase
            zcb_core_model_i.regs[r] = v;
            d = (n % 16 == 0) ? 16'h8000 : 16'($urandom);
            p = {$urandom, $urandom} & ~64'h3;
            tgt = p + 64'h4 + {{46{d[15]}}, d, 2'b00};
            c = e[4] && cond_of(e[3:2], v);
            gaps = (n % 3 == 0) ? 0 : $urandom % 3;
            // Every fifth slot holds a link branch, which must be ignored.
            slot = (n % 5 == 0) ? {6'h01, 5'h01, 5'h11, 16'h0010} : ($urandom & 32'h0000FFFF);
            step(1'b1, {e[15:10], r, e[9:5], d}, p, 1'b1);
            for (int g = 0; g <= gaps; g++)
            begin
                if (g == gaps)
                    step(1'b1, slot, p + 64'h4, 1'b1);
                else
                    step(1'b0, 32'h0, 64'h0, 1'($urandom % 2));
                #1;
                if (g == 0)
                begin
                    check("decoded", decoded, e[4]);
                    check("source select", src_sel, r);
                    check("link strobe", link_we, e[4] & e[0]);
                    check("early redirect", redirect | nullify, 1'b0);
                    if (e[4] & e[0])
                    begin
                        check("link register", link_reg, 5'd31);
                        check("link value", link_value, p + 64'h8);
                    end
                end
            end
            step(1'b0, 32'h0, 64'h0, 1'b1);
            #1;
            check("redirect", redirect, c);
            check("nullify", nullify, e[4] & e[1] & !c);
            check("slot branch ignored", decoded | link_we, 1'b0);
            if (c)
                check("target", target, tgt);
            if (e[4] & e[0])
                check("link in register file", zcb_core_model_i.regs[31], p + 64'h8);
        end
        // A reset between branch and slot drops the pending branch.
        zcb_core_model_i.regs[2] = 64'h1;
        step(1'b1, {6'h07, 5'h02, 5'h00, 16'h0001}, 64'h100, 1'b1);
        do_reset();
        step(1'b1, 32'h0, 64'h104, 1'b1);
        step(1'b0, 32'h0, 64'h0, 1'b1);
        #1;
        check("redirect after reset", redirect, 1'b0);
        // A branch presented while the clock enable is low must leave no trace.
        step(1'b1, {6'h07, 5'h02, 5'h00, 16'h0001}, 64'h200, 1'b0);
        step(1'b0, 32'h0, 64'h0, 1'b1);
        #1;
        check("frozen issue ignored", decoded, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
